// [bench/csd_far_model.sv]
// far side: flow-control peer and weak pull-up on the shared pin
`timescale 1ns/100ps
`default_nettype none
module csd_far_model (
  input wire logic selN,
  input wire logic selOe,
  input wire logic farN,
  input wire logic farOe,
  output logic pinLevel
);
  // the device wins a clash; a released pin settles at the pull-up
  always_comb begin
    if (selOe) begin
      pinLevel = selN;
    end else if (farOe) begin
      pinLevel = farN;
    end else begin
      pinLevel = 1'b1;
    end
  end
endmodule // csd_far_model
`default_nettype wire

// [bench/csd_pins_props.sv]
// concurrent checks on the chip-select pin block ports
`timescale 1ns/100ps
`default_nettype none
module csd_pins_props #(
  parameter PERIPH_N = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic busCycle,
  input wire logic muxAddrPhase,
  input wire logic busHold,
  input wire logic [3:0] midPinN,
  input wire logic [3:0] midPinOe,
  input wire logic upperPinN,
  input wire logic upperPinOe,
  input wire logic lowerPinN,
  input wire logic lowerPinOe,
  input wire logic [PERIPH_N-1:0] periphPinN,
  input wire logic [PERIPH_N-1:0] periphPinOe,
  input wire logic periphPin2In,
  input wire logic dramCycle,
  input wire logic txPending,
  input wire logic txStart,
  input wire logic port1RxEnable
);
  // one domain, synchronous reset masks every check
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_hold_float: assert property (busHold |=>
    !(|{midPinOe, upperPinOe, lowerPinOe, periphPinOe}))
    else $error("select driven in hold");
  // gpio may hold pins 1..3 low, so only fixed selects are watched
  a_idle_high: assert property (!busCycle |=>
    midPinN[0] && upperPinN && lowerPinN && (&periphPinN))
    else $error("select low outside cycle");
  a_reset_oe: assert property ($rose(reset_n) ##0 !busHold [*2] |=>
    upperPinOe && midPinOe[0])
    else $error("pins not driven after reset");
  a_cts_gate: assert property (txStart |-> txPending)
    else $error("frame start without data");
  // a withheld frame is only legal in clear-to-send use with the pin high
  a_cts_hold: assert property (txPending && !txStart |->
    periphPin2In && port1RxEnable)
    else $error("frame held with pin clear");
  a_rx_pin: assert property (!port1RxEnable |-> periphPin2In)
    else $error("receiver off with request low");
  a_flow_float: assert property (!port1RxEnable |=> !periphPinOe[2])
    else $error("shared pin driven in flow mode");
  a_periph_wins: assert property (!(&periphPinN) |-> !dramCycle)
    else $error("dram with peripheral hit");
  a_periph_mux: assert property ($fell(&periphPinN) |->
    $past(muxAddrPhase))
    else $error("peripheral select before address");
endmodule // csd_pins_props
bind csd_pins csd_pins_props #(.PERIPH_N(PERIPH_N)) csd_pins_props_i (
  .clock, .reset_n, .busCycle, .muxAddrPhase, .busHold, .midPinN,
  .midPinOe, .upperPinN, .upperPinOe, .lowerPinN, .lowerPinOe,
  .periphPinN, .periphPinOe, .periphPin2In, .dramCycle, .txPending,
  .txStart, .port1RxEnable);
`default_nettype wire

// [bench/tb.sv]
// self-checking testbench for the chip-select pin block
`timescale 1ns/100ps
`default_nettype none
`include "csd_map.vh"
module tb;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic busCycle, muxAddrPhase, ioSpace, byteHigh, byteLow;
  logic refreshCycle, busHold, upperPinN, upperPinOe, lowerPinN;
  logic lowerPinOe, periphPin2In, busWidth16, dramCycle, txPending;
  logic txStart, port1RxEnable, farN, farOe;
  logic [19:0] busAddr;
  logic [3:0] midPinN, midPinOe, periphPinN, periphPinOe;
  int error_cnt = 0;
  int checks_done = 0;
  csd_pins csd_pins_i (.clock, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .busCycle,
    .muxAddrPhase, .busAddr, .ioSpace, .byteHigh, .byteLow,
    .refreshCycle, .busHold, .midPinN, .midPinOe, .upperPinN,
    .upperPinOe, .lowerPinN, .lowerPinOe, .periphPinN, .periphPinOe,
    .periphPin2In, .busWidth16, .dramCycle, .txPending, .txStart,
    .port1RxEnable);
  csd_far_model csd_far_model_i (.selN(periphPinN[2]),
    .selOe(periphPinOe[2]), .farN, .farOe, .pinLevel(periphPin2In));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer; a read compares {pslverr, prdata} with e
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    if (!w) chk({pslverr, prdata}, e);
    if (w) chk(pslverr, e[32]);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one processor cycle; f = {mux, io, refresh, high, low}
  task automatic cyc(input logic [19:0] a, input logic [4:0] f);
    @(posedge clock);
    busCycle <= 1'b1;
    busAddr <= a;
    {muxAddrPhase, ioSpace, refreshCycle, byteHigh, byteLow} <= f;
    @(posedge clock);
    #1;
  endtask
  task automatic idle;
    @(posedge clock);
    busCycle <= 1'b0;
    {muxAddrPhase, refreshCycle, byteHigh, byteLow} <= 4'h0;
    @(posedge clock);
  endtask
  task automatic t_regs;
    xfer(0, `CSD_OFS_MID_CFG, 32'h0, `CSD_RST_MID_CFG);
    xfer(0, `CSD_OFS_PIO, 32'h0, `CSD_RST_PIO);
    xfer(0, `CSD_OFS_UPPER_SEL, 32'h0, `CSD_RST_UPPER_SEL);
    xfer(0, 8'h20, 32'h0, 33'h1_0000_0000);
    xfer(1, 8'h20, 32'h1, 33'h1_0000_0000);
    xfer(1, `CSD_OFS_AUX, 32'h5, 33'h0);
    xfer(0, `CSD_OFS_AUX, 32'h0, 33'h5);
    $display("regs done");
  endtask
  task automatic t_mid;
    xfer(1, `CSD_OFS_MID_BASE, 32'h4_0000, 33'h0);
    for (int r = 0; r < 4; r++) begin
      cyc(20'h4_0010 + 20'(r) * 20'h800, 5'h13);
      chk(midPinN, 4'hF ^ (4'h1 << r));
      chk(busWidth16, (r % 2) == 0);
      idle();
    end
    cyc(20'h4_2010, 5'h13);
    chk(midPinN, 4'hF);
    idle();
    $display("midrange done");
  endtask
  task automatic t_dram;
    cyc(20'hF_F010, 5'h13);
    chk(upperPinN, 1'b0);
    idle();
    xfer(1, `CSD_OFS_MID_CFG, 32'h2D, 33'h0);
    xfer(1, `CSD_OFS_UPPER_SEL, 32'h2D, 33'h0);
    cyc(20'hF_F010, 5'h12);
    chk({upperPinN, midPinN}, 5'h15);
    idle();
    cyc(20'hF_F010, 5'h11);
    chk({upperPinN, midPinN}, 5'h13);
    idle();
    cyc(20'hF_F010, 5'h14);
    chk(midPinN[2:1], 2'h0);
    idle();
    cyc(20'h4_1810, 5'h13);
    chk(midPinN, 4'hE);
    idle();
    xfer(1, `CSD_OFS_PERIPH, 32'hF_F000, 33'h0);
    cyc(20'hF_F110, 5'h13);
    chk({dramCycle, midPinN, periphPinN}, 9'h0FD);
    idle();
    cyc(20'hF_F110, 5'h03);
    chk(periphPinN, 4'hF);
    idle();
    cyc(20'hF_F410, 5'h12);
    chk({periphPinN, midPinN}, 8'hF5);
    idle();
    xfer(1, `CSD_OFS_PERIPH, 32'h1F_F000, 33'h0);
    cyc(20'hF_F110, 5'h1B);
    chk({dramCycle, upperPinN, periphPinN}, 6'h1D);
    idle();
    cyc(20'h0_0010, 5'h13);
    chk(lowerPinN, 1'b0);
    idle();
    xfer(1, `CSD_OFS_LOWER_SEL, 32'h2D, 33'h0);
    cyc(20'h0_0010, 5'h13);
    chk({dramCycle, lowerPinN, midPinN}, 6'h29);
    idle();
    #1;
    chk(lowerPinN, 1'b1);
    xfer(1, `CSD_OFS_PIO, 32'h5, 33'h0);
    xfer(1, `CSD_OFS_MID_CFG, 32'h1ED, 33'h0);
    cyc(20'hF_F410, 5'h12);
    chk(midPinN, 4'hB);
    idle();
    $display("dram done");
  endtask
  task automatic t_hold;
    @(posedge clock);
    busHold <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk({periphPin2In, midPinOe, upperPinOe, lowerPinOe, periphPinOe},
      11'h400);
    @(posedge clock);
    busHold <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({midPinOe[0], upperPinOe, lowerPinOe, periphPinOe}, 7'h7F);
    $display("hold done");
  endtask
  task automatic t_flow;
    xfer(1, `CSD_OFS_AUX, 32'h200, 33'h0);
    @(posedge clock);
    farOe <= 1'b1;
    txPending <= 1'b1;
    @(posedge clock);
    #1;
    chk({periphPinOe[2], txStart}, 2'h0);
    @(posedge clock);
    farN <= 1'b0;
    #1;
    chk(txStart, 1'b1);
    xfer(1, `CSD_OFS_AUX, 32'h300, 33'h0);
    #1;
    chk(port1RxEnable, 1'b1);
    @(posedge clock);
    farN <= 1'b1;
    #1;
    chk({port1RxEnable, txStart}, 2'h1);
    $display("flow done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, busCycle, muxAddrPhase, ioSpace} = 6'h0;
    {byteHigh, byteLow, refreshCycle, busHold, txPending, farOe} = 6'h0;
    farN = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    busAddr = 20'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_mid();
    t_dram();
    t_hold();
    t_flow();
    results();
  end
  // a hang counts as a mismatch
  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule // tb
`default_nettype wire

// [rtl/csd_map.vh]
// register map, field positions, reset values for the chip-select pin block
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define CSD_OFS_MID_BASE 8'h00
`define CSD_OFS_MID_CFG 8'h04
`define CSD_OFS_UPPER_SEL 8'h08
`define CSD_OFS_LOWER_SEL 8'h0C
`define CSD_OFS_PERIPH 8'h10
`define CSD_OFS_AUX 8'h14
`define CSD_OFS_PIO 8'h18
`define CSD_OFS_STATUS 8'h1C
// ************************************************************
// field positions
// ************************************************************
`define CSD_SIZE_LSB 0
`define CSD_SIZE_MSB 4
`define CSD_MID_WHOLE 5
`define CSD_MID_PIO_LSB 6
`define CSD_MID_PIO_MSB 8
`define CSD_ROW_EN 5
`define CSD_PER_IO 20
`define CSD_AUX_WIDTH_LSB 0
`define CSD_AUX_WIDTH_MSB 3
`define CSD_AUX_ENRX 8
`define CSD_AUX_FLOW 9
// ************************************************************
// reset values
// ************************************************************
`define CSD_RST_MID_BASE 32'h0000_0000
`define CSD_RST_MID_CFG 32'h0000_000D
`define CSD_RST_UPPER_SEL 32'h0000_000D
`define CSD_RST_LOWER_SEL 32'h0000_000D
`define CSD_RST_PERIPH 32'h0000_0000
`define CSD_RST_AUX 32'h0000_0000
`define CSD_RST_PIO 32'h0000_0007
`endif

// [rtl/csd_pins.v]
// chip-select, dram strobe and shared-pin logic with an apb register slave
`timescale 1ns/100ps
`default_nettype none
`include "csd_map.vh"

module csd_pins #(
  parameter ADDR_W = 20,
  parameter PERIPH_N = 4
) (
  input wire clock,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // processor bus cycle
  input wire busCycle,
  input wire muxAddrPhase,
  input wire [ADDR_W-1:0] busAddr,
  input wire ioSpace,
  input wire byteHigh,
  input wire byteLow,
  input wire refreshCycle,
  input wire busHold,
  // select pins, active low, with output enables
  output reg [3:0] midPinN,
  output reg [3:0] midPinOe,
  output reg upperPinN,
  output reg upperPinOe,
  output reg lowerPinN,
  output reg lowerPinOe,
  output reg [PERIPH_N-1:0] periphPinN,
  output reg [PERIPH_N-1:0] periphPinOe,
  input wire periphPin2In,
  // status toward the bus and dram engine
  output reg busWidth16,
  output reg dramCycle,
  // serial port 1 flow control
  input wire txPending,
  output wire txStart,
  output wire port1RxEnable
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [31:0] midBase_reg; // midrange block base address
  reg [31:0] midCfg_reg; // size, whole-range, pio assignment
  reg [31:0] upperSel_reg; // upper block size, upper row enable
  reg [31:0] lowerSel_reg; // lower block size, lower row enable
  reg [31:0] periph_reg; // peripheral base and space
  reg [31:0] aux_reg; // widths and flow-control selection
  reg [31:0] pio_reg; // levels for pins given to general i/o

  wire setup = psel & ~penable;
  wire wrStrobe = psel & penable & pwrite;
  reg mapped;

  // zero-wait slave: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // address decode of the mapped words
  always @* begin
    case (paddr)
      `CSD_OFS_MID_BASE, `CSD_OFS_MID_CFG, `CSD_OFS_UPPER_SEL,
      `CSD_OFS_LOWER_SEL, `CSD_OFS_PERIPH, `CSD_OFS_AUX,
      `CSD_OFS_PIO, `CSD_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // register writes, taken in the access phase
  always @(posedge clock) begin
    if (!reset_n) begin
      midBase_reg <= `CSD_RST_MID_BASE;
      midCfg_reg <= `CSD_RST_MID_CFG;
      upperSel_reg <= `CSD_RST_UPPER_SEL;
      lowerSel_reg <= `CSD_RST_LOWER_SEL;
      periph_reg <= `CSD_RST_PERIPH;
      aux_reg <= `CSD_RST_AUX;
      pio_reg <= `CSD_RST_PIO;
    end else if (wrStrobe) begin
      case (paddr)
        `CSD_OFS_MID_BASE: midBase_reg <= pwdata;
        `CSD_OFS_MID_CFG: midCfg_reg <= pwdata;
        `CSD_OFS_UPPER_SEL: upperSel_reg <= pwdata;
        `CSD_OFS_LOWER_SEL: lowerSel_reg <= pwdata;
        `CSD_OFS_PERIPH: periph_reg <= pwdata;
        `CSD_OFS_AUX: aux_reg <= pwdata;
        `CSD_OFS_PIO: pio_reg <= pwdata;
        default: ; // status is read-only, others unmapped
      endcase
    end
  end

  // ************************************************************
  // configuration fields
  // ************************************************************
  wire [4:0] midLog = midCfg_reg[`CSD_SIZE_MSB:`CSD_SIZE_LSB];
  wire midWhole = midCfg_reg[`CSD_MID_WHOLE];
  wire [2:0] midPio = midCfg_reg[`CSD_MID_PIO_MSB:`CSD_MID_PIO_LSB];
  wire [4:0] upLog = upperSel_reg[`CSD_SIZE_MSB:`CSD_SIZE_LSB];
  wire [4:0] loLog = lowerSel_reg[`CSD_SIZE_MSB:`CSD_SIZE_LSB];
  wire upRowEn = upperSel_reg[`CSD_ROW_EN];
  wire loRowEn = lowerSel_reg[`CSD_ROW_EN];
  wire dramOn = upRowEn | loRowEn;
  wire enrxSel = aux_reg[`CSD_AUX_ENRX];
  wire flowOn = aux_reg[`CSD_AUX_FLOW];

  // ************************************************************
  // address decode
  // ************************************************************
  wire [ADDR_W-1:0] ones = {ADDR_W{1'b1}};
  wire [ADDR_W-1:0] midMask = ~(ones << midLog);
  wire [ADDR_W-1:0] upMask = ~(ones << upLog);
  wire [ADDR_W-1:0] loMask = ~(ones << loLog);
  wire [ADDR_W-1:0] midB = midBase_reg[ADDR_W-1:0];
  wire [ADDR_W-1:0] midOff = busAddr & midMask;
  // midrange block is aligned to its own size
  wire inMid = ((busAddr ^ midB) & ~midMask) == {ADDR_W{1'b0}};
  // block is split into four equal regions
  wire [4:0] regShift = (midLog > 5'h02) ? midLog - 5'h02 : 5'h00;
  wire [ADDR_W-1:0] midRegion = midOff >> regShift;
  wire [1:0] region = midRegion[1:0];
  // upper block ends at the top, lower block starts at zero
  wire inUpper = (busAddr & ~upMask) == (ones & ~upMask);
  wire inLower = (busAddr & ~loMask) == {ADDR_W{1'b0}};
  // peripheral block: PERIPH_N windows of 256 bytes each
  wire [ADDR_W-1:0] perB = periph_reg[ADDR_W-1:0];
  wire [ADDR_W-1:0] perOff = busAddr - perB;
  wire perSpaceOk = periph_reg[`CSD_PER_IO] == ioSpace;
  wire perHit = perSpaceOk && (busAddr >= perB) &&
    (perOff[ADDR_W-1:8] < PERIPH_N);
  wire [ADDR_W-9:0] perIdx = perOff[ADDR_W-1:8];

  // dram only when no peripheral claims the same address
  wire dramHitUp = upRowEn & inUpper & ~ioSpace;
  wire dramHitLo = loRowEn & inLower & ~ioSpace;
  wire dramHit = (dramHitUp | dramHitLo) & ~perHit;
  wire memCycle = busCycle & ~ioSpace;

  // ************************************************************
  // peripheral selects
  // ************************************************************
  // selects wait for the multiplexed address phase, then hold
  reg perArmed_reg;
  always @(posedge clock) begin
    if (!reset_n) begin
      perArmed_reg <= 1'b0;
    end else if (!busCycle) begin
      perArmed_reg <= 1'b0;
    end else if (muxAddrPhase) begin
      perArmed_reg <= 1'b1;
    end
  end
  wire perActive = busCycle & (muxAddrPhase | perArmed_reg);

  // ************************************************************
  // next pin values
  // ************************************************************
  reg [3:0] midNext;
  wire [PERIPH_N-1:0] perNext; // one bit per window, from the loop below
  reg upperNext;
  reg lowerNext;
  reg width16Next;
  reg casHi;
  reg casLo;
  reg rasUp;
  reg rasLo;
  integer k;

  // column and row strobes for dram and refresh cycles
  always @* begin
    casHi = 1'b0;
    casLo = 1'b0;
    rasUp = 1'b0;
    rasLo = 1'b0;
    if (refreshCycle && dramOn) begin
      casHi = 1'b1;
      casLo = 1'b1;
      rasUp = upRowEn;
      rasLo = loRowEn;
    end else if (memCycle && dramHit) begin
      casHi = byteHigh;
      casLo = byteLow;
      rasUp = dramHitUp;
      rasLo = dramHitLo;
    end
  end

  // chip select decode; outputs are active high here
  always @* begin
    midNext = 4'h0;
    upperNext = 1'b0;
    lowerNext = 1'b0;
    width16Next = 1'b0;
    if (memCycle && !dramHit && inMid) begin
      if (midWhole) begin
        midNext[0] = 1'b1;
      end else begin
        midNext[region] = 1'b1;
      end
      width16Next = aux_reg[`CSD_AUX_WIDTH_LSB + region];
    end
    if (memCycle && inUpper && !upRowEn) begin
      upperNext = 1'b1;
    end
    if (memCycle && inLower && !loRowEn) begin
      lowerNext = 1'b1;
    end
    // reassignment of selects 1..3 only in whole-range mode
    if (midWhole) begin
      for (k = 1; k < 4; k = k + 1) begin
        if (midPio[k-1]) begin
          midNext[k] = ~pio_reg[k-1];
        end
      end
      if (dramOn && !midPio[0]) begin
        midNext[1] = casHi;
      end
      if (dramOn && !midPio[1]) begin
        midNext[2] = casLo;
      end
      if (upRowEn && !midPio[2]) begin
        midNext[3] = rasUp;
      end
    end
  end

  // one comparator per peripheral window
  genvar g;
  generate
    for (g = 0; g < PERIPH_N; g = g + 1) begin : gPer
      assign perNext[g] = perActive && perHit &&
        (perIdx == g);
    end
  endgenerate

  // ************************************************************
  // registered pins
  // ************************************************************
  // pins go high between cycles, except mid pins 1..3 given to gpio, which keep their levels; hold floats them, pull keeps high
  always @(posedge clock) begin
    if (!reset_n) begin
      midPinN <= 4'hF;
      midPinOe <= 4'h0;
      upperPinN <= 1'b1;
      upperPinOe <= 1'b0;
      lowerPinN <= 1'b1;
      lowerPinOe <= 1'b0;
      periphPinN <= {PERIPH_N{1'b1}};
      periphPinOe <= {PERIPH_N{1'b0}};
      busWidth16 <= 1'b0;
      dramCycle <= 1'b0;
    end else begin
      midPinN <= ~midNext;
      upperPinN <= ~upperNext;
      // lower pin carries the row strobe when enabled
      lowerPinN <= loRowEn ? ~rasLo : ~lowerNext;
      periphPinN <= ~perNext;
      midPinOe <= {4{~busHold}};
      upperPinOe <= ~busHold;
      lowerPinOe <= ~busHold;
      periphPinOe <= {PERIPH_N{~busHold}};
      if (PERIPH_N > 2) begin
        // shared pin becomes an input under flow control
        periphPinOe[2] <= ~busHold & ~flowOn;
      end
      busWidth16 <= width16Next;
      dramCycle <= (memCycle & dramHit) | (refreshCycle & dramOn);
    end
  end

  // ************************************************************
  // serial port 1 flow control on the shared pin
  // ************************************************************
  wire ctsMode = flowOn & ~enrxSel;
  wire enrxMode = flowOn & enrxSel;
  // pin is active low; clear to send when it reads low
  wire ctsOk = ~periphPin2In;
  // in clear-to-send mode a frame starts only when the pin allows it at that moment;
  // otherwise the data simply waits in the transmit register
  assign txStart = txPending & (~ctsMode | ctsOk);
  assign port1RxEnable = ~enrxMode | ~periphPin2In;

  // ************************************************************
  // read data
  // ************************************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `CSD_OFS_MID_BASE: prdata <= midBase_reg;
        `CSD_OFS_MID_CFG: prdata <= midCfg_reg;
        `CSD_OFS_UPPER_SEL: prdata <= upperSel_reg;
        `CSD_OFS_LOWER_SEL: prdata <= lowerSel_reg;
        `CSD_OFS_PERIPH: prdata <= periph_reg;
        `CSD_OFS_AUX: prdata <= aux_reg;
        `CSD_OFS_PIO: prdata <= pio_reg;
        `CSD_OFS_STATUS: prdata <= {19'h00000, ctsOk, dramCycle,
          busWidth16, lowerPinN, upperPinN, midPinN, periphPinN[3:0]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // csd_pins
`default_nettype wire
